// ---- logic/bioz_mux_pkg.sv ----
// constants for the electrode switch matrix and lead detection block
package bioz_mux_pkg;

  // ----------------------------------------------------------------
  // register bus and map (index; byte address is four times it)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_MUX_CONFIG_ONE = 8'h41;
  localparam logic [7:0] IDX_MUX_CONFIG_TWO = 8'h42;
  localparam logic [7:0] IDX_PIN_ASSIGNMENT = 8'h43;
  localparam logic [7:0] IDX_FACTORY_LOAD_ERROR = 8'h44;
  localparam logic [7:0] IDX_LEAD_DETECT_CONFIG = 8'h50;
  localparam logic [7:0] IDX_CHANNEL_CONTROL = 8'h60;
  localparam logic [7:0] IDX_DETECT_STATUS = 8'h61;

  // writable bits per register; reserved bits read zero
  localparam logic [7:0] MASK_MUX_CONFIG_ONE = 8'he7;
  localparam logic [7:0] MASK_MUX_CONFIG_TWO = 8'he3;
  localparam logic [7:0] MASK_PIN_ASSIGNMENT = 8'hff;
  localparam logic [7:0] MASK_LEAD_DETECT = 8'hff;
  localparam logic [7:0] MASK_CHANNEL_CONTROL = 8'h33;
  localparam logic [7:0] MASK_DETECT_STATUS = 8'h9f;

  // reset values
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_FACTORY_LOAD_ERROR = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_TEST_LOAD_SELECT = 6;
  localparam int POS_TEST_LOAD_ENABLE = 5;
  localparam int POS_CAL_ONLY = 2;
  localparam int POS_SWITCH_ENABLE = 1;
  localparam int POS_CAL_ENABLE = 0;
  localparam int POS_SKIN_LOAD_SELECT = 6;
  localparam int POS_SKIN_LOAD_ENABLE = 5;
  localparam int POS_GUARD_DRIVE_ENABLE = 1;
  localparam int POS_INPUT_CAP_COMP_ENABLE = 0;
  localparam int POS_POS_SENSE_SELECT = 6;
  localparam int POS_NEG_SENSE_SELECT = 4;
  localparam int POS_POS_DRIVE_SELECT = 2;
  localparam int POS_NEG_DRIVE_SELECT = 0;
  localparam int POS_LEAD_ON_ENABLE = 7;
  localparam int POS_LEAD_OFF_ENABLE = 6;
  localparam int POS_EXT_LEAD_OFF = 5;
  localparam int POS_DRIVE_RANGE_ENABLE = 4;
  localparam int POS_LEAD_OFF_POLARITY = 3;
  localparam int POS_LEAD_OFF_LEVEL = 0;
  localparam int POS_DRIVE_MODE = 4;
  localparam int POS_QUADRATURE_ENABLE = 1;
  localparam int POS_INPHASE_ENABLE = 0;
  localparam int POS_STAT_DRIVE_RANGE = 4;
  localparam int POS_STAT_LEAD_ON = 7;

  // ----------------------------------------------------------------
  // drive modes and load values
  // ----------------------------------------------------------------
  localparam logic [1:0] DRV_MODE_VOLTAGE = 2'h1;
  localparam logic [1:0] DRV_MODE_HBRIDGE = 2'h2;
  localparam logic [1:0] PIN_CODE_FORBIDDEN = 2'h3;
  localparam logic [12:0] TEST_OHMS_0 = 13'd5100;
  localparam logic [12:0] TEST_OHMS_1 = 13'd900;
  localparam logic [12:0] TEST_OHMS_2 = 13'd600;
  localparam logic [12:0] TEST_OHMS_3 = 13'd280;
  // skin-response load in units of 100 ohm
  localparam logic [13:0] SKIN_HOHMS_0 = 14'd257;
  localparam logic [13:0] SKIN_HOHMS_1 = 14'd1010;
  localparam logic [13:0] SKIN_HOHMS_2 = 14'd5050;
  localparam logic [13:0] SKIN_HOHMS_3 = 14'd10000;
  localparam logic [6:0] LOFF_NA_1 = 7'd5;
  localparam logic [6:0] LOFF_NA_2 = 7'd10;
  localparam logic [6:0] LOFF_NA_3 = 7'd20;
  localparam logic [6:0] LOFF_NA_4 = 7'd50;
  localparam logic [6:0] LOFF_NA_MAX = 7'd100;

endpackage

// ---- logic/bioz_mux_cfg.sv ----
// electrode switch matrix decode, internal loads and lead detection control
//
// Decided for this implementation: the Wishbone register port.
module bioz_mux_cfg
  import bioz_mux_pkg::*;
#(
  parameter logic [7:0] FACTORY_ERROR = RST_FACTORY_LOAD_ERROR
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // wishbone classic slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADDR_W-1:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  // analog comparator levels from the front end
  input wire logic i_cmp_pos_high,
  input wire logic i_cmp_pos_low,
  input wire logic i_cmp_neg_high,
  input wire logic i_cmp_neg_low,
  input wire logic i_cmp_drive_range,
  input wire logic i_cmp_lead_on,
  // electrode switches: bit0 pin 1/4, bit1 pin 2a/3a, bit2 pin 2b/3b
  output logic [2:0] o_sw_pos_sense,
  output logic [2:0] o_sw_neg_sense,
  output logic [2:0] o_sw_pos_drive,
  output logic [2:0] o_sw_neg_drive,
  // calibration pins 1..4
  output logic [3:0] o_sw_cal,
  // internal loads and input helpers
  output logic o_test_load_on,
  output logic [12:0] o_test_load_ohms,
  output logic o_skin_load_on,
  output logic [13:0] o_skin_load_hohms,
  output logic o_guard_drive_on,
  output logic o_input_cap_comp_on,
  // lead detection
  output logic o_lead_on_det_on,
  output logic o_lead_off_det_on,
  output logic o_lead_off_ext_pins,
  output logic o_lead_off_pos_sinks,
  output logic [6:0] o_lead_off_na,
  output logic o_drive_range_mon_on
);

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] pin_onehot(input logic [1:0] code);
    logic [2:0] r;
    r = 3'h0;
    case (code)
      2'h0: r = 3'h1;
      2'h1: r = 3'h2;
      2'h2: r = 3'h4;
      default: r = 3'h0;
    endcase
    return r;
  endfunction

  function automatic logic [12:0] test_ohms(input logic [1:0] code);
    logic [12:0] r;
    r = TEST_OHMS_0;
    case (code)
      2'h1: r = TEST_OHMS_1;
      2'h2: r = TEST_OHMS_2;
      2'h3: r = TEST_OHMS_3;
      default: r = TEST_OHMS_0;
    endcase
    return r;
  endfunction

  function automatic logic [13:0] skin_hohms(input logic [1:0] code);
    logic [13:0] r;
    r = SKIN_HOHMS_0;
    case (code)
      2'h1: r = SKIN_HOHMS_1;
      2'h2: r = SKIN_HOHMS_2;
      2'h3: r = SKIN_HOHMS_3;
      default: r = SKIN_HOHMS_0;
    endcase
    return r;
  endfunction

  function automatic logic [6:0] loff_na(input logic [2:0] code);
    logic [6:0] r;
    r = 7'h00;
    case (code)
      3'h0: r = 7'h00;
      3'h1: r = LOFF_NA_1;
      3'h2: r = LOFF_NA_2;
      3'h3: r = LOFF_NA_3;
      3'h4: r = LOFF_NA_4;
      default: r = LOFF_NA_MAX;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // comparator synchronisers
  // ----------------------------------------------------------------
  logic [5:0] cmp_meta_q;
  logic [5:0] cmp_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmp_meta_q <= 6'h00;
      cmp_q <= 6'h00;
    end else begin
      cmp_meta_q <= {i_cmp_lead_on, i_cmp_drive_range, i_cmp_pos_high,
                     i_cmp_pos_low, i_cmp_neg_high, i_cmp_neg_low};
      cmp_q <= cmp_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // register file and bus slave
  // ----------------------------------------------------------------
  logic [7:0] cfg1_q, cfg1_d;
  logic [7:0] cfg2_q, cfg2_d;
  logic [7:0] pin_q, pin_d;
  logic [7:0] lead_q, lead_d;
  logic [7:0] chan_q, chan_d;
  logic [7:0] stat_q, stat_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [7:0] idx;
  logic hit;
  logic wr;
  logic [7:0] wdat;
  logic chan_run;
  logic loff_run;
  logic [7:0] events;

  assign chan_run = chan_q[POS_INPHASE_ENABLE] | chan_q[POS_QUADRATURE_ENABLE];
  assign loff_run = lead_q[POS_LEAD_OFF_ENABLE] & chan_run;

  always_comb begin
    idx = i_wb_adr[ADDR_W-1:2];
    hit = i_wb_cyc & i_wb_stb & ~ack_q;
    wr = hit & i_wb_we & i_wb_sel[0];
    wdat = i_wb_dat[7:0];
    cfg1_d = cfg1_q;
    cfg2_d = cfg2_q;
    pin_d = pin_q;
    lead_d = lead_q;
    chan_d = chan_q;
    ack_d = hit;
    rdat_d = 32'h0;
    events = 8'h00;
    events[3:0] = cmp_q[3:0] & {4{loff_run}};
    events[POS_STAT_DRIVE_RANGE] = cmp_q[4] & lead_q[POS_DRIVE_RANGE_ENABLE];
    events[POS_STAT_LEAD_ON] = cmp_q[5] & lead_q[POS_LEAD_ON_ENABLE] & ~chan_run;
    stat_d = stat_q;
    if (wr) begin
      case (idx)
        IDX_MUX_CONFIG_ONE: cfg1_d = wdat & MASK_MUX_CONFIG_ONE;
        IDX_MUX_CONFIG_TWO: cfg2_d = wdat & MASK_MUX_CONFIG_TWO;
        IDX_PIN_ASSIGNMENT: pin_d = wdat & MASK_PIN_ASSIGNMENT;
        IDX_LEAD_DETECT_CONFIG: lead_d = wdat & MASK_LEAD_DETECT;
        IDX_CHANNEL_CONTROL: chan_d = wdat & MASK_CHANNEL_CONTROL;
        IDX_DETECT_STATUS: stat_d = stat_q & ~wdat;
        default: cfg1_d = cfg1_q;
      endcase
    end
    // a new event in the clearing cycle still sets its flag
    stat_d = (stat_d | events) & MASK_DETECT_STATUS;
    if (hit && !i_wb_we) begin
      case (idx)
        IDX_MUX_CONFIG_ONE: rdat_d[7:0] = cfg1_q;
        IDX_MUX_CONFIG_TWO: rdat_d[7:0] = cfg2_q;
        IDX_PIN_ASSIGNMENT: rdat_d[7:0] = pin_q;
        IDX_FACTORY_LOAD_ERROR: rdat_d[7:0] = FACTORY_ERROR;
        IDX_LEAD_DETECT_CONFIG: rdat_d[7:0] = lead_q;
        IDX_CHANNEL_CONTROL: rdat_d[7:0] = chan_q;
        IDX_DETECT_STATUS: rdat_d[7:0] = stat_q;
        default: rdat_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg1_q <= RST_CONFIG;
      cfg2_q <= RST_CONFIG;
      pin_q <= RST_CONFIG;
      lead_q <= RST_CONFIG;
      chan_q <= RST_CONFIG;
      stat_q <= RST_CONFIG;
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      cfg1_q <= cfg1_d;
      cfg2_q <= cfg2_d;
      pin_q <= pin_d;
      lead_q <= lead_d;
      chan_q <= chan_d;
      stat_q <= stat_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  // ----------------------------------------------------------------
  // switch matrix and analog control decode
  // ----------------------------------------------------------------
  logic mux_en;
  logic cal_en;
  logic el_on;
  logic cal_on;
  logic drv_forced;
  logic [1:0] pos_drive_code;
  logic [1:0] neg_drive_code;
  logic [2:0] pos_sense_d, neg_sense_d, pos_drive_d, neg_drive_d;
  logic [3:0] cal_d;

  always_comb begin
    mux_en = cfg1_q[POS_SWITCH_ENABLE];
    cal_en = cfg1_q[POS_CAL_ENABLE];
    // cal enable alone keeps electrodes; cal enable together with cal-only drops them
    el_on = mux_en & ~(cal_en & cfg1_q[POS_CAL_ONLY]);
    cal_on = mux_en & cal_en;
    drv_forced = (chan_q[POS_DRIVE_MODE+:2] == DRV_MODE_VOLTAGE) ||
                 (chan_q[POS_DRIVE_MODE+:2] == DRV_MODE_HBRIDGE);
    pos_drive_code = drv_forced ? 2'h0 : pin_q[POS_POS_DRIVE_SELECT+:2];
    neg_drive_code = drv_forced ? 2'h0 : pin_q[POS_NEG_DRIVE_SELECT+:2];
    pos_sense_d = el_on ? pin_onehot(pin_q[POS_POS_SENSE_SELECT+:2]) : 3'h0;
    neg_sense_d = el_on ? pin_onehot(pin_q[POS_NEG_SENSE_SELECT+:2]) : 3'h0;
    pos_drive_d = el_on ? pin_onehot(pos_drive_code) : 3'h0;
    neg_drive_d = el_on ? pin_onehot(neg_drive_code) : 3'h0;
    // pins 1..4 carry positive drive, positive sense, negative sense, negative drive
    cal_d = {4{cal_on}};
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sw_pos_sense <= 3'h0;
      o_sw_neg_sense <= 3'h0;
      o_sw_pos_drive <= 3'h0;
      o_sw_neg_drive <= 3'h0;
      o_sw_cal <= 4'h0;
      o_test_load_on <= 1'b0;
      o_test_load_ohms <= TEST_OHMS_0;
      o_skin_load_on <= 1'b0;
      o_skin_load_hohms <= SKIN_HOHMS_0;
      o_guard_drive_on <= 1'b0;
      o_input_cap_comp_on <= 1'b0;
      o_lead_on_det_on <= 1'b0;
      o_lead_off_det_on <= 1'b0;
      o_lead_off_ext_pins <= 1'b0;
      o_lead_off_pos_sinks <= 1'b0;
      o_lead_off_na <= 7'h00;
      o_drive_range_mon_on <= 1'b0;
    end else begin
      o_sw_pos_sense <= pos_sense_d;
      o_sw_neg_sense <= neg_sense_d;
      o_sw_pos_drive <= pos_drive_d;
      o_sw_neg_drive <= neg_drive_d;
      o_sw_cal <= cal_d;
      o_test_load_on <= cfg1_q[POS_TEST_LOAD_ENABLE];
      o_test_load_ohms <= test_ohms(cfg1_q[POS_TEST_LOAD_SELECT+:2]);
      o_skin_load_on <= cfg2_q[POS_SKIN_LOAD_ENABLE];
      o_skin_load_hohms <= skin_hohms(cfg2_q[POS_SKIN_LOAD_SELECT+:2]);
      o_guard_drive_on <= cfg2_q[POS_GUARD_DRIVE_ENABLE];
      o_input_cap_comp_on <= cfg2_q[POS_INPUT_CAP_COMP_ENABLE];
      o_lead_on_det_on <= lead_q[POS_LEAD_ON_ENABLE] & ~chan_run;
      o_lead_off_det_on <= loff_run;
      o_lead_off_ext_pins <= lead_q[POS_EXT_LEAD_OFF];
      o_lead_off_pos_sinks <= lead_q[POS_LEAD_OFF_POLARITY];
      o_lead_off_na <= loff_na(lead_q[POS_LEAD_OFF_LEVEL+:3]);
      o_drive_range_mon_on <= lead_q[POS_DRIVE_RANGE_ENABLE];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_mux_off_all: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !mux_en |=> (o_sw_cal == 4'h0) && (o_sw_pos_sense == 3'h0) && (o_sw_neg_drive == 3'h0))
    else $error("pins connected while switch matrix disabled");

  a_el_no_cal: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (mux_en && !cal_en && pin_q[7:6] != PIN_CODE_FORBIDDEN) |=>
      (o_sw_cal == 4'h0) && $onehot(o_sw_pos_sense))
    else $error("electrode routing wrong without calibration");

  a_cal_with_el: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (mux_en && cal_en && !cfg1_q[POS_CAL_ONLY] && pin_q[5:4] == 2'h1) |=>
      (o_sw_cal == 4'hf) && (o_sw_neg_sense == 3'h2))
    else $error("calibration pins or electrodes missing");

  a_cal_only_mode: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (mux_en && cal_en && cfg1_q[POS_CAL_ONLY]) |=>
      (o_sw_cal == 4'hf) && (o_sw_pos_drive == 3'h0) && (o_sw_neg_sense == 3'h0))
    else $error("electrodes connected in calibration-only mode");

  a_cal_map_whole: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_sw_cal == 4'h0) || (o_sw_cal == 4'hf))
    else $error("calibration pins switched partly");

  a_forbidden_code: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (pin_q[7:6] == PIN_CODE_FORBIDDEN) |=> (o_sw_pos_sense == 3'h0))
    else $error("forbidden sense code connected a pin");

  a_drive_forced: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (el_on && drv_forced) |=> (o_sw_pos_drive == 3'h1) && (o_sw_neg_drive == 3'h1))
    else $error("drive not forced to pins 1 and 4");

  a_test_ohms: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cfg1_q[7:6] == 2'h2) |=> (o_test_load_ohms == 13'd600))
    else $error("test load value wrong");

  a_lead_on_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    chan_run |=> !o_lead_on_det_on)
    else $error("lead-on detect with a channel running");

  a_loff_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (stat_q[3] && !(wr && idx == IDX_DETECT_STATUS)) |=> stat_q[3])
    else $error("lead-off flag lost without a clear");

  a_wb_ack_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack ##1 !o_wb_ack)
    else $error("bus acknowledge not a single cycle");

  c_cal_only: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    o_sw_cal == 4'hf && o_sw_pos_sense == 3'h0);
  c_loff_flag: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(stat_q[3]));
  c_flag_clear: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(stat_q[POS_STAT_DRIVE_RANGE]));

endmodule

// ---- verification/bioz_mux_cfg_tb.sv ----
// self-checking testbench for the electrode switch matrix configuration block
module bioz_mux_cfg_tb
  import bioz_mux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk, rst_n, cyc, stb, we, ack;
  logic [ADDR_W-1:0] adr;
  logic [31:0] wdat, rdat;
  logic [3:0] sel;
  logic c_ph, c_pl, c_nh, c_nl, c_dr, c_lon;
  logic [2:0] ps, ns, pd, nd;
  logic [3:0] cal;
  logic tl_on, sk_on, gd_on, cc_on, lon_on, loff_on, ext_on, pol, drm_on;
  logic [12:0] tl_ohm;
  logic [13:0] sk_ho;
  logic [6:0] na;
  int failures, samples_checked, cycles;
  bioz_mux_cfg bioz_mux_cfg_i (.i_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_ack(ack),
    .o_wb_dat(rdat), .i_cmp_pos_high(c_ph), .i_cmp_pos_low(c_pl), .i_cmp_neg_high(c_nh),
    .i_cmp_neg_low(c_nl), .i_cmp_drive_range(c_dr), .i_cmp_lead_on(c_lon),
    .o_sw_pos_sense(ps), .o_sw_neg_sense(ns), .o_sw_pos_drive(pd), .o_sw_neg_drive(nd),
    .o_sw_cal(cal), .o_test_load_on(tl_on), .o_test_load_ohms(tl_ohm), .o_skin_load_on(sk_on),
    .o_skin_load_hohms(sk_ho), .o_guard_drive_on(gd_on), .o_input_cap_comp_on(cc_on),
    .o_lead_on_det_on(lon_on), .o_lead_off_det_on(loff_on), .o_lead_off_ext_pins(ext_on),
    .o_lead_off_pos_sinks(pol), .o_lead_off_na(na), .o_drive_range_mon_on(drm_on));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // classic single cycle; the request stays up through the edge that samples ack high
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                    input logic [3:0] s, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    sel <= s;
    // no local limit: only the bench timeout ends a hang
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    // taken at the first edge, answered one cycle later
    chk("bus ack wait", 32'd2, 32'(n));
    chk("read upper", 32'h0, {8'h00, rdat[31:8]});
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, idx, d, 4'hf, q);
    @(posedge clk);
    #1;
  endtask
  task automatic rdchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    wb(1'b0, idx, 8'h00, 4'hf, q);
    chk(name, {24'h0, exp}, {24'h0, q});
  endtask
  function automatic logic [2:0] hot(input logic [1:0] c);
    return (c == 2'h3) ? 3'b000 : 3'b001 << c;
  endfunction
  task automatic complete_run();
    $display("counts: %0d checked, %0d failures", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] q;
    chk("reset test ohms", 32'(TEST_OHMS_0), 32'(tl_ohm));
    chk("reset switches", 32'h0, {ps, ns, pd, nd, cal});
    wr(IDX_MUX_CONFIG_ONE, 8'hff);
    rdchk("cfg one mask", IDX_MUX_CONFIG_ONE, MASK_MUX_CONFIG_ONE);
    wr(IDX_MUX_CONFIG_TWO, 8'hff);
    rdchk("cfg two mask", IDX_MUX_CONFIG_TWO, MASK_MUX_CONFIG_TWO);
    wb(1'b1, IDX_MUX_CONFIG_TWO, 8'h00, 4'he, q);
    rdchk("sel0 low write", IDX_MUX_CONFIG_TWO, MASK_MUX_CONFIG_TWO);
    wr(IDX_FACTORY_LOAD_ERROR, 8'h5a);
    rdchk("factory error", IDX_FACTORY_LOAD_ERROR, RST_FACTORY_LOAD_ERROR);
    rdchk("unmapped", 8'h7f, 8'h00);
    $display("test registers done");
  endtask
  task automatic t_loads();
    logic [12:0] t[4];
    logic [13:0] k[4];
    t = '{TEST_OHMS_0, TEST_OHMS_1, TEST_OHMS_2, TEST_OHMS_3};
    k = '{SKIN_HOHMS_0, SKIN_HOHMS_1, SKIN_HOHMS_2, SKIN_HOHMS_3};
    wr(IDX_MUX_CONFIG_ONE, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(IDX_MUX_CONFIG_ONE, {c[1:0], c[0], 5'h00});
      wr(IDX_MUX_CONFIG_TWO, {c[1:0], ~c[0], 3'h0, c[0], c[1]});
      chk("test ohms", 32'(t[c]), 32'(tl_ohm));
      chk("test on", 32'(c[0]), 32'(tl_on));
      chk("skin hohms", 32'(k[c]), 32'(sk_ho));
      chk("skin on", {31'h0, ~c[0]}, 32'(sk_on));
      chk("guard cap", {30'h0, c[0], c[1]}, {30'h0, gd_on, cc_on});
    end
    $display("test loads done");
  endtask
  task automatic t_decode();
    logic el, cp;
    wr(IDX_MUX_CONFIG_TWO, 8'h00);
    wr(IDX_PIN_ASSIGNMENT, 8'b01_10_00_00);
    for (int m = 0; m < 8; m++) begin
      wr(IDX_MUX_CONFIG_ONE, {5'h00, m[2:0]});
      el = m[1] & ~(m[0] & m[2]);
      cp = m[1] & m[0];
      chk("electrodes", {20'h0, {3{el}} & 3'b010, {3{el}} & 3'b100, {3{el}} & 3'b001,
          {3{el}} & 3'b001}, {20'h0, ps, ns, pd, nd});
      chk("cal pins", {28'h0, {4{cp}}}, {28'h0, cal});
    end
    $display("test decode done");
  endtask
  task automatic t_pins();
    logic [2:0] d;
    wr(IDX_MUX_CONFIG_ONE, 8'h02);
    for (int m = 0; m < 4; m++) begin
      wr(IDX_CHANNEL_CONTROL, {2'h0, m[1:0], 4'h0});
      for (int c = 0; c < 4; c++) begin
        wr(IDX_PIN_ASSIGNMENT, {4{c[1:0]}});
        d = (m == 1 || m == 2) ? 3'b001 : hot(c[1:0]);
        chk("sense", {26'h0, hot(c[1:0]), hot(c[1:0])}, {26'h0, ps, ns});
        chk("pos drive", 32'(d), 32'(pd));
        chk("neg drive", 32'(d), 32'(nd));
      end
    end
    $display("test pins done");
  endtask
  task automatic t_lead();
    logic [6:0] a[8];
    a = '{7'd0, LOFF_NA_1, LOFF_NA_2, LOFF_NA_3, LOFF_NA_4, LOFF_NA_MAX, LOFF_NA_MAX,
          LOFF_NA_MAX};
    wr(IDX_MUX_CONFIG_ONE, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(IDX_CHANNEL_CONTROL, {6'h00, i[1:0]});
      wr(IDX_LEAD_DETECT_CONFIG, {i[2:0], ~i[0], i[1], i[2:0]});
      chk("lead on det", 32'(i[2] & (i[1:0] == 2'b00)), 32'(lon_on));
      chk("lead off det", 32'(i[1] & (i[1:0] != 2'b00)), 32'(loff_on));
      chk("ext pins", 32'(i[0]), 32'(ext_on));
      chk("range mon", {31'h0, ~i[0]}, 32'(drm_on));
      chk("polarity", 32'(i[1]), 32'(pol));
      chk("current", 32'(a[i]), 32'(na));
    end
    $display("test lead config done");
  endtask
  task automatic t_status();
    wr(IDX_CHANNEL_CONTROL, 8'h01);
    // lead-on enabled too, so the channel gate is really exercised
    wr(IDX_LEAD_DETECT_CONFIG, 8'hd0);
    @(posedge clk);
    {c_ph, c_pl, c_nh, c_nl, c_dr, c_lon} <= 6'h3f;
    repeat (6) @(posedge clk);
    {c_ph, c_pl, c_nh, c_nl, c_dr, c_lon} <= 6'h00;
    repeat (4) @(posedge clk);
    // lead-on is gated off while a channel runs
    rdchk("status flags", IDX_DETECT_STATUS, 8'h1f);
    wr(IDX_DETECT_STATUS, 8'hff);
    rdchk("status clear", IDX_DETECT_STATUS, 8'h00);
    wr(IDX_CHANNEL_CONTROL, 8'h00);
    wr(IDX_LEAD_DETECT_CONFIG, 8'h80);
    @(posedge clk);
    c_lon <= 1'b1;
    repeat (6) @(posedge clk);
    rdchk("lead on flag", IDX_DETECT_STATUS, 8'h80);
    $display("test status done");
  endtask
  // ----------------------------------------------------------------
  // clock, reset, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // the whole run needs a few hundred cycles; anything far beyond is a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    {cyc, stb, we, adr, wdat, sel} = '0;
    {c_ph, c_pl, c_nh, c_nl, c_dr, c_lon} = 6'h00;
    failures = 0;
    samples_checked = 0;
    cycles = 0;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    t_regs();
    t_loads();
    t_decode();
    t_pins();
    t_lead();
    t_status();
    complete_run();
  end
endmodule
